// ==== hdl/sdp_cmd_if.sv ====
// command pin interface of a four-bank sdram: decode, power states, masks
`timescale 1ns/1ps
`default_nettype none
module sdp_cmd_if
    import sdp_pkg::*;
(
    // clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // configuration strap: reduced page size
    input wire logic reduced_page_in,
    // command pins
    input wire logic cke_in,
    input wire logic cs_n_in,
    input wire logic ras_n_in,
    input wire logic cas_n_in,
    input wire logic we_n_in,
    input wire logic bank_select_bit0_in,
    input wire logic bank_select_bit1_in,
    input wire logic [ADDR_W-1:0] addr_in,
    input wire logic byte_mask_lane0_in,
    input wire logic byte_mask_lane1_in,
    input wire logic byte_mask_lane2_in,
    input wire logic byte_mask_lane3_in,
    input wire logic deep_pd_req_in,
    // data pins, three signals each lane
    input wire logic [DATA_W-1:0] dq_in,
    output logic [DATA_W-1:0] dq_out,
    output logic [LANES-1:0] dq_oe_n_out,
    // read data from the array side
    input wire logic [DATA_W-1:0] rd_data_in,
    // write beats toward the array side
    output logic wr_valid_out,
    input wire logic wr_ready_in,
    output sdp_wbeat_t wr_beat_out,
    input wire logic wr_ready_stall_in,
    // status
    output logic wr_full_out,
    output sdp_state_t state_out,
    output logic [BANKS-1:0] bank_open_out,
    output logic [BANKS*ADDR_W-1:0] open_rows_out,
    output logic [1:0] rd_bank_out,
    output logic [ADDR_W-1:0] rd_row_out,
    output logic [ADDR_W-1:0] rd_col_out,
    output logic mode_load_out,
    output logic [MODE_SEL_W-1:0] mode_sel_out,
    output logic [ADDR_W-1:0] mode_op_out,
    output logic refresh_out,
    output logic self_refresh_out,
    output logic deep_pd_out
);
    // ********************************************************************
    // input capture and command decode
    // ********************************************************************
    sdp_cmd_t cmd_r; // pins registered at the rising edge
    logic cke_r; // clock enable as last sampled
    sdp_state_t state_r;
    logic [BANKS-1:0] bank_open_r;
    logic [ADDR_W-1:0] row_r [BANKS];
    logic [BURST_W-1:0] burst_cnt_r; // beats left in current burst
    logic [BURST_W-1:0] burst_len_r; // burst length from mode op-code
    logic burst_wr_r; // burst is a write
    logic burst_ap_r; // auto precharge at burst end
    logic [1:0] burst_bank_r;
    logic [ADDR_W-1:0] col_r;
    logic [RD_MASK_LAT-1:0][LANES-1:0] rd_mask_pipe_r;
    logic [RD_MASK_LAT-1:0] rd_act_pipe_r;
    logic [DATA_W-1:0] dq_r;
    logic self_ref_r;
    logic deep_pd_r;
    logic low_power;
    logic run;
    logic [2:0] code;
    logic sel;
    logic fifo_ready;
    logic fifo_in_valid;
    sdp_wbeat_t beat;

    // the two power-down states stop the input buffers; clock suspend does not
    assign low_power = (state_r == ST_PD_PRE) || (state_r == ST_PD_ACT);

    // command, bank, address and mask pins sampled on the rising edge, frozen while in low power
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            cmd_r <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1, default: '0};
        end else if (!low_power) begin
            cmd_r <= '{cs_n: cs_n_in, ras_n: ras_n_in, cas_n: cas_n_in,
                       we_n: we_n_in,
                       bank: {bank_select_bit1_in, bank_select_bit0_in},
                       addr: addr_in,
                       mask: {byte_mask_lane3_in, byte_mask_lane2_in,
                              byte_mask_lane1_in, byte_mask_lane0_in}};
        end
    end

    // clock enable watched every edge; in low power it acts as a wake level
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            cke_r <= 1'b1;
        end else begin
            cke_r <= cke_in;
        end
    end

    // device advances only while clock enable is high and neither power-down state is held
    assign run = cke_r && !low_power;
    assign sel = !cmd_r.cs_n;
    assign code = sel ? {cmd_r.ras_n, cmd_r.cas_n, cmd_r.we_n} : CMD_NOP;

    // ********************************************************************
    // operating state
    // ********************************************************************
    // choose power state on clock enable low from the present condition
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            state_r <= ST_IDLE;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (!cke_in) begin
                        state_r <= ST_PD_PRE;
                    end else if (run && (code == CMD_ACT)) begin
                        state_r <= ST_ACTIVE;
                    end
                end
                ST_ACTIVE: begin
                    if (!cke_in) begin
                        state_r <= ST_PD_ACT;
                    end else if (run && (code == CMD_RD || code == CMD_WR)) begin
                        state_r <= ST_BURST;
                    end else if (run && code == CMD_PRE && (cmd_r.addr[AP_BIT] ||
                                 bank_open_r == (BANKS'(1) << cmd_r.bank))) begin
                        state_r <= ST_IDLE;
                    end
                end
                ST_BURST: begin
                    if (!cke_in) begin
                        state_r <= ST_SUSPEND;
                    end else if (burst_cnt_r == '0) begin
                        state_r <= (bank_open_r == '0) ? ST_IDLE : ST_ACTIVE;
                    end
                end
                // wake is taken from the raw level, not from a clocked command
                ST_PD_PRE: begin
                    if (cke_in) begin
                        state_r <= ST_IDLE;
                    end
                end
                ST_PD_ACT: begin
                    if (cke_in) begin
                        state_r <= ST_ACTIVE;
                    end
                end
                ST_SUSPEND: begin
                    if (cke_in) begin
                        state_r <= ST_BURST;
                    end
                end
                default: begin
                    state_r <= ST_IDLE;
                end
            endcase
        end
    end

    // self refresh entered by refresh with clock enable falling; deep by burst stop with the request input
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            self_ref_r <= 1'b0;
            deep_pd_r <= 1'b0;
        end else if (state_r == ST_IDLE && !cke_in) begin
            self_ref_r <= sel && (code == CMD_REF);
            deep_pd_r <= deep_pd_req_in && (code == CMD_BST);
        end else if (cke_in && state_r == ST_PD_PRE) begin
            self_ref_r <= 1'b0;
            deep_pd_r <= 1'b0;
        end
    end

    // ********************************************************************
    // banks, rows and precharge
    // ********************************************************************
    // activate latches row; precharge closes one bank or all
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            bank_open_r <= '0;
            for (int b = 0; b < BANKS; b++) begin
                row_r[b] <= '0;
            end
        end else if (run) begin
            if (code == CMD_ACT) begin
                bank_open_r[cmd_r.bank] <= 1'b1;
                row_r[cmd_r.bank] <= row_of(cmd_r.addr, reduced_page_in);
            end else if (code == CMD_PRE) begin
                if (cmd_r.addr[AP_BIT]) begin
                    bank_open_r <= '0;
                end else begin
                    bank_open_r[cmd_r.bank] <= 1'b0;
                end
            end else if (state_r == ST_BURST && burst_cnt_r == BURST_W'(1) && burst_ap_r) begin
                bank_open_r[burst_bank_r] <= 1'b0;
            end
        end
    end

    // ********************************************************************
    // burst counter and mode register
    // ********************************************************************
    // clock advances the column counter; new access restarts it
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            burst_cnt_r <= '0;
            burst_wr_r <= 1'b0;
            burst_ap_r <= 1'b0;
            burst_bank_r <= '0;
            col_r <= '0;
        end else if (run) begin
            if (code == CMD_RD || code == CMD_WR) begin
                burst_cnt_r <= burst_len_r;
                burst_wr_r <= (code == CMD_WR);
                burst_ap_r <= cmd_r.addr[AP_BIT];
                burst_bank_r <= cmd_r.bank;
                col_r <= col_of(cmd_r.addr, reduced_page_in);
            end else if (code == CMD_BST) begin
                burst_cnt_r <= '0;
            end else if (burst_cnt_r != '0 && (fifo_ready || !burst_wr_r)) begin
                burst_cnt_r <= burst_cnt_r - 1'b1;
                col_r <= col_r + 1'b1;
            end
        end
    end

    // mode load keeps the op-code; with bank 0 its low bits pick burst length
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            mode_load_out <= 1'b0;
            mode_sel_out <= '0;
            mode_op_out <= '0;
            burst_len_r <= BURST_LEN_RST;
            refresh_out <= 1'b0;
        end else begin
            mode_load_out <= run && (code == CMD_LMR);
            refresh_out <= run && (code == CMD_REF);
            if (run && code == CMD_LMR) begin
                mode_sel_out <= cmd_r.bank;
                mode_op_out <= cmd_r.addr;
                if (cmd_r.bank == '0) begin
                    burst_len_r <= BURST_W'(1) << cmd_r.addr[1:0];
                end
            end
        end
    end

    // ********************************************************************
    // read path: output registers and mask latency
    // ********************************************************************
    // mask and read activity delayed two clocks before reaching the drivers
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rd_mask_pipe_r <= '0;
            rd_act_pipe_r <= '0;
            dq_r <= '0;
        end else if (run) begin
            rd_mask_pipe_r <= {rd_mask_pipe_r[0], cmd_r.mask};
            rd_act_pipe_r <= {rd_act_pipe_r[0], burst_cnt_r != '0 && !burst_wr_r};
            dq_r <= rd_data_in;
        end
    end

    // drivers off where masked; enable active low
    always_comb begin
        for (int l = 0; l < LANES; l++) begin
            dq_oe_n_out[l] = !(rd_act_pipe_r[1] && !rd_mask_pipe_r[1][l]);
        end
    end
    assign dq_out = dq_r;

    // ********************************************************************
    // write path through the fifo
    // ********************************************************************
    assign fifo_in_valid = run && burst_wr_r && burst_cnt_r != '0 && !wr_ready_stall_in;
    always_comb begin
        beat.bank = burst_bank_r;
        beat.row = row_r[burst_bank_r];
        beat.col = col_r;
        beat.byte_en = ~cmd_r.mask;
        beat.data = dq_in;
    end

    sdp_fifo #(
        .WIDTH(WBEAT_W),
        .DEPTH(FIFO_DEPTH)
    ) u_wr_fifo (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .in_valid_in(fifo_in_valid),
        .in_ready_out(fifo_ready),
        .in_data_in(beat),
        .out_valid_out(wr_valid_out),
        .out_ready_in(wr_ready_in),
        .out_data_out(wr_beat_out)
    );

    // ********************************************************************
    // status outputs
    // ********************************************************************
    assign wr_full_out = !fifo_ready;
    assign state_out = state_r;
    assign bank_open_out = bank_open_r;
    assign rd_bank_out = burst_bank_r;
    assign rd_row_out = row_r[burst_bank_r];
    assign rd_col_out = col_r;
    assign self_refresh_out = self_ref_r;
    assign deep_pd_out = deep_pd_r;
    always_comb begin
        for (int b = 0; b < BANKS; b++) begin
            open_rows_out[b*ADDR_W +: ADDR_W] = row_r[b];
        end
    end

    // ********************************************************************
    // assertions
    // ********************************************************************
    a_cs_masks_cmd: assert property (@(posedge clk_in) disable iff (srst_in)
        (cmd_r.cs_n && state_r == ST_IDLE && cke_in && cke_r) |=> state_r == ST_IDLE)
        else $error("command acted on with chip select high");
    a_act_opens_bank: assert property (@(posedge clk_in) disable iff (srst_in)
        (run && code == CMD_ACT) |=> bank_open_r[$past(cmd_r.bank)])
        else $error("activate did not open bank");
    a_pre_all_banks: assert property (@(posedge clk_in) disable iff (srst_in)
        (run && code == CMD_PRE && cmd_r.addr[AP_BIT]) |=> bank_open_r == '0)
        else $error("all-bank precharge left a bank open");
    a_rd_mask_float: assert property (@(posedge clk_in) disable iff (srst_in)
        (run && cmd_r.mask[0]) ##1 run ##1 run |-> dq_oe_n_out[0])
        else $error("masked read byte driven");
    a_pd_entry: assert property (@(posedge clk_in) disable iff (srst_in)
        (state_r == ST_ACTIVE && !cke_in) |=> state_r == ST_PD_ACT)
        else $error("active power-down not entered");
    a_pd_wake: assert property (@(posedge clk_in) disable iff (srst_in)
        (state_r == ST_PD_PRE && cke_in) |=> state_r == ST_IDLE)
        else $error("power-down wake missed");
    a_pd_frozen: assert property (@(posedge clk_in) disable iff (srst_in)
        (low_power && !cke_in) |=> $stable(cmd_r) && $stable(bank_open_r))
        else $error("inputs taken during power-down");
    a_mode_opcode: assert property (@(posedge clk_in) disable iff (srst_in)
        (run && code == CMD_LMR) |=> mode_load_out && mode_op_out == $past(cmd_r.addr))
        else $error("mode op-code not taken");
    a_suspend_hold: assert property (@(posedge clk_in) disable iff (srst_in)
        (state_r == ST_SUSPEND && !cke_r) |=> $stable(burst_cnt_r))
        else $error("burst advanced while suspended");
endmodule // sdp_cmd_if
`default_nettype wire

// ==== hdl/sdp_fifo.sv ====
// synchronous valid/ready fifo for write beats
`timescale 1ns/1ps
`default_nettype none
module sdp_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic clk_in,
    input wire logic srst_in,
    // fill side
    input wire logic in_valid_in,
    output logic in_ready_out,
    input wire logic [WIDTH-1:0] in_data_in,
    // drain side
    output logic out_valid_out,
    input wire logic out_ready_in,
    output logic [WIDTH-1:0] out_data_out
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_r [DEPTH]; // storage
    logic [AW-1:0] wptr_r; // write index
    logic [AW-1:0] rptr_r; // read index
    logic [AW:0] cnt_r; // fill level
    logic push;
    logic pop;

    assign in_ready_out = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid_out = (cnt_r != '0);
    assign push = in_valid_in && in_ready_out;
    assign pop = out_valid_out && out_ready_in;
    assign out_data_out = mem_r[rptr_r];

    // storage write, no reset needed for data
    always_ff @(posedge clk_in) begin
        if (push) begin
            mem_r[wptr_r] <= in_data_in;
        end
    end

    // pointers and level
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            wptr_r <= '0;
            rptr_r <= '0;
            cnt_r <= '0;
        end else begin
            if (push) begin
                wptr_r <= (wptr_r == AW'(DEPTH-1)) ? '0 : wptr_r + 1'b1;
            end
            if (pop) begin
                rptr_r <= (rptr_r == AW'(DEPTH-1)) ? '0 : rptr_r + 1'b1;
            end
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule // sdp_fifo
`default_nettype wire

// ==== hdl/sdp_pkg.sv ====
// package: constants, states and carrier types of the sdram command pin interface
package sdp_pkg;
    // ********************************************************************
    // geometry
    // ********************************************************************
    localparam int ADDR_W = 14;
    localparam int DATA_W = 32;
    localparam int LANES = 4;
    localparam int BANKS = 4;
    localparam int STD_ROW_W = 13;
    localparam int STD_COL_W = 10;
    localparam int RED_ROW_W = 14;
    localparam int RED_COL_W = 9;
    localparam int STD_ROWS = 8192;
    localparam int STD_COLS = 1024;
    localparam int RED_ROWS = 16384;
    localparam int RED_COLS = 512;
    localparam int AP_BIT = 10;
    localparam int MODE_SEL_W = 2;
    // ********************************************************************
    // timing and buffering
    // ********************************************************************
    localparam int CLK_PERIOD_NS = 40;
    localparam int RD_MASK_LAT = 2;
    localparam int FIFO_DEPTH = 8;
    localparam int BURST_W = 4;
    localparam logic [BURST_W-1:0] BURST_LEN_RST = 4'h4;
    // ********************************************************************
    // command codes {ras_n, cas_n, we_n}
    // ********************************************************************
    localparam logic [2:0] CMD_NOP = 3'h7;
    localparam logic [2:0] CMD_ACT = 3'h3;
    localparam logic [2:0] CMD_RD = 3'h5;
    localparam logic [2:0] CMD_WR = 3'h4;
    localparam logic [2:0] CMD_BST = 3'h6;
    localparam logic [2:0] CMD_PRE = 3'h2;
    localparam logic [2:0] CMD_REF = 3'h1;
    localparam logic [2:0] CMD_LMR = 3'h0;

    // device operating states, one-hot
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_ACTIVE = 6'h02,
        ST_BURST = 6'h04,
        ST_PD_PRE = 6'h08,
        ST_PD_ACT = 6'h10,
        ST_SUSPEND = 6'h20
    } sdp_state_t;

    // command pins as sampled
    typedef struct packed {
        logic cs_n;
        logic ras_n;
        logic cas_n;
        logic we_n;
        logic [1:0] bank;
        logic [ADDR_W-1:0] addr;
        logic [LANES-1:0] mask;
    } sdp_cmd_t;

    // one write beat handed to the array side
    typedef struct packed {
        logic [1:0] bank;
        logic [ADDR_W-1:0] row;
        logic [ADDR_W-1:0] col;
        logic [LANES-1:0] byte_en;
        logic [DATA_W-1:0] data;
    } sdp_wbeat_t;

    localparam int WBEAT_W = $bits(sdp_wbeat_t);

    // row and column split for the chosen configuration
    function automatic logic [ADDR_W-1:0] col_of(input logic [ADDR_W-1:0] a,
                                                 input logic reduced);
        col_of = reduced ? (a & 14'h01FF) : (a & 14'h03FF);
    endfunction

    function automatic logic [ADDR_W-1:0] row_of(input logic [ADDR_W-1:0] a,
                                                 input logic reduced);
        row_of = reduced ? a : (a & 14'h1FFF);
    endfunction
endpackage

// ==== tb/sdp_ctrl_model.sv ====
// controller-side model that puts bench commands onto the device pins
`timescale 1ns/1ps
`default_nettype none
module sdp_ctrl_model
    import sdp_pkg::*;
(
    // clock and command from the bench
    input wire logic clk_in,
    input wire sdp_cmd_t cmd_in,
    // device pins
    output logic cs_n_out,
    output logic ras_n_out,
    output logic cas_n_out,
    output logic we_n_out,
    output logic [1:0] bank_out,
    output logic [ADDR_W-1:0] addr_out,
    output logic [LANES-1:0] mask_out
);
    // last address put out while selected
    logic [ADDR_W-1:0] last_addr_r = 14'h0000;

    // ************************************************************
    // pin drive
    // ************************************************************
    // strobes and chip select together form the command
    assign cs_n_out = cmd_in.cs_n;
    assign ras_n_out = cmd_in.ras_n;
    assign cas_n_out = cmd_in.cas_n;
    assign we_n_out = cmd_in.we_n;
    assign bank_out = cmd_in.bank;
    assign mask_out = cmd_in.mask;
    // a deselected bus is not kind: show the inverse of the last value
    assign addr_out = cmd_in.cs_n ? ~last_addr_r : cmd_in.addr;

    // remember the address of each selected command
    always_ff @(posedge clk_in) begin
        if (!cmd_in.cs_n) begin
            last_addr_r <= cmd_in.addr;
        end
    end
endmodule // sdp_ctrl_model
`default_nettype wire

// ==== tb/tb.sv ====
// self-checking bench for the sdram command pin interface
`timescale 1ns/1ps
`default_nettype none
module tb
    import sdp_pkg::*;
;
    // ************************************************************
    // signals
    // ************************************************************
    // one table row: pins in, state and open banks out
    typedef struct packed {
        logic cs_n;
        logic [2:0] op;
        logic [1:0] bk;
        logic [13:0] a;
        sdp_state_t st;
        logic [3:0] open;
        logic [13:0] row;
    } sdp_row_t;
    localparam sdp_row_t ROWS [6] = '{
        '{1'b0, CMD_ACT, 2'h1, 14'h0123, ST_ACTIVE, 4'h2, 14'h0123},
        '{1'b1, CMD_ACT, 2'h2, 14'h0456, ST_ACTIVE, 4'h2, 14'h0000},
        '{1'b0, CMD_ACT, 2'h2, 14'h3FFF, ST_ACTIVE, 4'h6, 14'h1FFF},
        '{1'b0, CMD_PRE, 2'h1, 14'h0000, ST_ACTIVE, 4'h4, 14'h0000},
        '{1'b0, CMD_ACT, 2'h3, 14'h0ABC, ST_ACTIVE, 4'hC, 14'h0ABC},
        '{1'b0, CMD_PRE, 2'h0, 14'h0400, ST_IDLE, 4'h0, 14'h0000}};
    logic clk_in = 1'b0;
    logic srst_in = 1'b1;
    logic cke = 1'b1;
    logic wr_ready = 1'b0;
    logic [31:0] dq_w = 32'hAABBCCDD;
    logic [31:0] rd_w = 32'h12345678;
    sdp_cmd_t cmd = '{1'b1, 1'b1, 1'b1, 1'b1, 2'h0, 14'h0000, 4'h0};
    logic red = 1'b0;
    logic cs_n, ras_n, cas_n, we_n, wr_valid, wr_full, ld, rf;
    logic [1:0] bk;
    logic [13:0] addr, rcol, rrow, mop;
    logic [3:0] msk, oe_n, bopen;
    logic [31:0] dq_o;
    logic [55:0] rows_o;
    sdp_wbeat_t beat;
    sdp_state_t st;
    int mismatches = 0;
    int tests_run = 0;
    int n;

    // ************************************************************
    // instances
    // ************************************************************
    sdp_ctrl_model ctl (.clk_in(clk_in), .cmd_in(cmd), .cs_n_out(cs_n),
        .ras_n_out(ras_n), .cas_n_out(cas_n), .we_n_out(we_n), .bank_out(bk),
        .addr_out(addr), .mask_out(msk));
    sdp_cmd_if dut (.clk_in(clk_in), .srst_in(srst_in), .reduced_page_in(red),
        .cke_in(cke), .cs_n_in(cs_n), .ras_n_in(ras_n), .cas_n_in(cas_n),
        .we_n_in(we_n), .bank_select_bit0_in(bk[0]), .bank_select_bit1_in(bk[1]),
        .addr_in(addr), .byte_mask_lane0_in(msk[0]), .byte_mask_lane1_in(msk[1]),
        .byte_mask_lane2_in(msk[2]), .byte_mask_lane3_in(msk[3]),
        .deep_pd_req_in(1'b0), .dq_in(dq_w), .dq_out(dq_o), .dq_oe_n_out(oe_n),
        .rd_data_in(rd_w), .wr_valid_out(wr_valid), .wr_ready_in(wr_ready),
        .wr_beat_out(beat), .wr_ready_stall_in(1'b0), .wr_full_out(wr_full),
        .state_out(st), .bank_open_out(bopen), .open_rows_out(rows_o),
        .rd_bank_out(), .rd_row_out(rrow), .rd_col_out(rcol), .mode_load_out(ld),
        .mode_sel_out(), .mode_op_out(mop), .refresh_out(rf), .self_refresh_out(),
        .deep_pd_out());

    // ************************************************************
    // tasks
    // ************************************************************
    // count a comparison and report a mismatch at once
    task automatic chk(input logic ok, input string what);
        tests_run++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask

    // one command cycle, then no-op; the mask stays for burst beats
    task automatic issue(input logic c, input logic [2:0] op, input logic [1:0] b,
                         input logic [13:0] a, input logic [3:0] m);
        @(posedge clk_in);
        cmd <= '{c, op[2], op[1], op[0], b, a, m};
        @(posedge clk_in);
        cmd <= '{1'b1, 1'b1, 1'b1, 1'b1, 2'h0, 14'h0000, m};
        @(posedge clk_in);
        #1;
    endtask

    // print the counts and the verdict, then stop
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    // 40 ns clock
    initial begin
        forever #20 clk_in = ~clk_in;
    end

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        repeat (6) @(posedge clk_in);
        srst_in <= 1'b0;
        // table of plain commands, checked two edges after the pins
        foreach (ROWS[i]) begin
            issue(ROWS[i].cs_n, ROWS[i].op, ROWS[i].bk, ROWS[i].a, 4'h0);
            chk(st === ROWS[i].st && bopen === ROWS[i].open, "state");
            if (ROWS[i].op == CMD_ACT && !ROWS[i].cs_n)
                chk(rows_o[int'(ROWS[i].bk)*14 +: 14] === ROWS[i].row, "row");
            $display("row %0d done", i);
        end
        // mode load: op-code taken from address, burst of 8
        issue(1'b0, CMD_LMR, 2'h0, 14'h0003, 4'h0);
        chk(ld === 1'b1 && mop === 14'h0003, "mode load");
        // masked write burst fills the fifo while the array stalls
        issue(1'b0, CMD_ACT, 2'h0, 14'h0005, 4'h0);
        issue(1'b0, CMD_WR, 2'h0, 14'h0010, 4'h5);
        repeat (14) @(posedge clk_in);
        #1;
        chk(wr_full === 1'b1 && wr_valid === 1'b1, "fifo full");
        chk(beat.byte_en === 4'hA && beat.col === 14'h0010 && beat.row === 14'h0005, "beat");
        chk(beat.data === 32'hAABBCCDD && beat.bank === 2'h0, "beat data");
        @(posedge clk_in);
        wr_ready <= 1'b1;
        n = 0;
        repeat (20) begin
            #1;
            if (wr_valid === 1'b1) n++;
            @(posedge clk_in);
        end
        chk(n == 8 && wr_full === 1'b0, "drain count");
        $display("write test done");
        // masked read: lanes 0 and 1 float, 2 and 3 drive
        issue(1'b0, CMD_RD, 2'h0, 14'h0020, 4'h3);
        chk(st === ST_BURST && rcol === 14'h0020 && rrow === 14'h0005, "read target");
        for (n = 0; n < 8 && oe_n !== 4'h3; n++) begin
            @(posedge clk_in);
            #1;
        end
        chk(n == 2, "read lanes");
        chk(dq_o === 32'h12345678, "read data");
        // clock enable low mid-burst: suspend, column counter frozen
        @(posedge clk_in);
        cke <= 1'b0;
        repeat (4) @(posedge clk_in);
        #1;
        chk(st === ST_SUSPEND && rcol === 14'h0024, "suspend");
        @(posedge clk_in);
        cke <= 1'b1;
        for (n = 0; n < 16 && st !== ST_ACTIVE; n++) begin
            @(posedge clk_in);
            #1;
        end
        chk(n == 6, "burst end");
        $display("read test done");
        // clock enable low in idle: power-down, command ignored
        issue(1'b0, CMD_PRE, 2'h0, 14'h0400, 4'h0);
        @(posedge clk_in);
        cke <= 1'b0;
        issue(1'b0, CMD_ACT, 2'h1, 14'h0001, 4'h0);
        chk(st === ST_PD_PRE && bopen === 4'h0, "power-down");
        @(posedge clk_in);
        cke <= 1'b1;
        repeat (3) @(posedge clk_in);
        #1;
        chk(st === ST_IDLE, "wake");
        $display("power test done");
        // reset in mid-run
        issue(1'b0, CMD_ACT, 2'h2, 14'h0002, 4'h0);
        @(posedge clk_in);
        srst_in <= 1'b1;
        repeat (2) @(posedge clk_in);
        #1;
        chk(st === ST_IDLE && bopen === 4'h0 && oe_n === 4'hF && ld === 1'b0, "reset");
        // release with the reduced page strap, first commands right after
        @(posedge clk_in);
        srst_in <= 1'b0;
        red <= 1'b1;
        issue(1'b0, CMD_REF, 2'h0, 14'h0000, 4'h0);
        chk(rf === 1'b1 && st === ST_IDLE, "refresh");
        issue(1'b0, CMD_ACT, 2'h1, 14'h3FFF, 4'h0);
        chk(st === ST_ACTIVE && rows_o[27:14] === 14'h3FFF, "reduced row");
        $display("reset test done");
        wrap_up();
    end
endmodule // tb
`default_nettype wire
